// File: inc/mgc_pkg.sv
package mgc_pkg;
   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [11:0] MGC_IDX_DRAM_TIMING_A = 12'h048;
   localparam logic [11:0] MGC_IDX_DUAL_LANE_CFG = 12'h16F;
   localparam logic [11:0] MGC_IDX_GEAR_MODE = 12'h170;
   // Byte addresses derived from the indices
   localparam logic [13:0] MGC_ADR_DRAM_TIMING_A = {MGC_IDX_DRAM_TIMING_A,
                                                   2'b00};
   localparam logic [13:0] MGC_ADR_DUAL_LANE_CFG = {MGC_IDX_DUAL_LANE_CFG,
                                                   2'b00};
   localparam logic [13:0] MGC_ADR_GEAR_MODE = {MGC_IDX_GEAR_MODE, 2'b00};
   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int MGC_TAL_LSB = 28;
   localparam int MGC_TAL_MSB = 30;
   localparam int MGC_TIMING_LOW_MSB = 27;
   localparam logic [31:0] MGC_TIMING_WMASK = 32'h7FFFFFFF;
   localparam logic [31:0] MGC_TIMING_RST = 32'h00000000;
   localparam logic [7:0] MGC_DUAL_LANE_RST = 8'h00;
   localparam logic [2:0] MGC_TAL_RST = 3'h0;
   // ---------------------------------------------------------------
   // Gear ratio modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MGC_RATIO_1TO1 = 2'h0,
      MGC_RATIO_5TO4 = 2'h1,
      MGC_RATIO_4TO5 = 2'h3,
      MGC_RATIO_RSVD = 2'h2
   } mgc_ratio_t;
   localparam logic [1:0] MGC_MODE_RST = 2'h0;
   // Selector values delivered by the gearing registers elsewhere
   typedef struct packed {
      logic [31:0] nb_gear_first;
      logic [31:0] nb_gear_second;
      logic [31:0] sb_gear;
      logic [7:0] sb_valid;
      logic [7:0] nb_bubble;
      logic [7:0] host_full;
   } mgc_sel_t;
   // Effective selectors as the crossing logic sees them
   typedef struct packed {
      mgc_sel_t sel;
      logic [7:0] dual_lane;
      logic [2:0] cas_al;
   } mgc_eff_t;
endpackage : mgc_pkg

// File: core/mgc_gear_cfg.sv
// Implementation choice: the AHB-Lite register port.
module mgc_gear_cfg (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Raw selectors from the gearing registers
   input mgc_pkg::mgc_sel_t SEL_IN,
   // Effective selectors to the crossing logic
   output mgc_pkg::mgc_eff_t EFF_OUT,
   output logic [31:0] TIMING_A
);
   import mgc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [31:0] timing_ff, nxt_timing;   // Timing register A
   logic [7:0] dual_ff, nxt_dual;        // Dual-lane-valid selector
   logic [1:0] mode_ff, nxt_mode;        // Active gear ratio
   logic wr_pend_ff, nxt_wr_pend;        // Write in data phase
   logic [13:0] wr_adr_ff, nxt_wr_adr;   // Address of pending write
   logic [31:0] rdata_ff, nxt_rdata;     // Read data
   mgc_eff_t eff_ff, nxt_eff;            // Effective selectors
   logic addr_ok;                        // Valid address phase
   mgc_ratio_t ratio;                    // Decoded ratio

   // Read mux over register values
   function automatic logic [31:0] rd_mux(input logic [13:0] a,
                                         input logic [31:0] t,
                                         input logic [7:0] d,
                                         input logic [1:0] m);
      logic [31:0] r;
      r = 32'h00000000;
      unique case (a)
         MGC_ADR_DRAM_TIMING_A: r = t & MGC_TIMING_WMASK;
         MGC_ADR_DUAL_LANE_CFG: r = {24'h000000, d};
         MGC_ADR_GEAR_MODE: r = {30'h0, m};
         default: r = 32'h00000000;  // Unmapped reads as zero
      endcase
      return r;
   endfunction : rd_mux

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   assign addr_ok = HSEL & HTRANS[1] & HREADY;

   // Next state of registers and bus pipeline
   always_comb begin
      nxt_timing = timing_ff;
      nxt_dual = dual_ff;
      nxt_mode = mode_ff;
      // Data phase write lands here
      if (wr_pend_ff) begin
         unique case (wr_adr_ff)
            MGC_ADR_DRAM_TIMING_A: begin
               nxt_timing = HWDATA & MGC_TIMING_WMASK;
            end
            MGC_ADR_DUAL_LANE_CFG: begin
               nxt_dual = HWDATA[7:0];
            end
            MGC_ADR_GEAR_MODE: begin
               nxt_mode = HWDATA[1:0];
            end
            default: begin
               nxt_mode = mode_ff;  // Unmapped write is dropped
            end
         endcase
      end
      nxt_wr_pend = addr_ok & HWRITE;
      nxt_wr_adr = addr_ok ? {HADDR[13:2], 2'b00} : wr_adr_ff;
      // Bypass from the write so back-to-back reads see new data
      nxt_rdata = (addr_ok & ~HWRITE) ?
                  rd_mux({HADDR[13:2], 2'b00}, nxt_timing, nxt_dual,
                         nxt_mode) : 32'h00000000;
   end

   // Register stage
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         timing_ff <= MGC_TIMING_RST;
         dual_ff <= MGC_DUAL_LANE_RST;
         mode_ff <= MGC_MODE_RST;
         wr_pend_ff <= 1'b0;
         wr_adr_ff <= 14'h0;
         rdata_ff <= 32'h00000000;
      end else begin
         timing_ff <= nxt_timing;
         dual_ff <= nxt_dual;
         mode_ff <= nxt_mode;
         wr_pend_ff <= nxt_wr_pend;
         wr_adr_ff <= nxt_wr_adr;
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Mode gating of selectors
   // ---------------------------------------------------------------
   assign ratio = mgc_ratio_t'(mode_ff);

   // Effective selectors for the present ratio
   always_comb begin
      nxt_eff = '0;
      nxt_eff.sel.nb_gear_first = SEL_IN.nb_gear_first;
      nxt_eff.sel.sb_gear = SEL_IN.sb_gear;
      nxt_eff.cas_al = timing_ff[MGC_TAL_MSB:MGC_TAL_LSB];
      unique case (ratio)
         MGC_RATIO_4TO5: begin
            nxt_eff.sel.nb_gear_second = SEL_IN.nb_gear_second;
            nxt_eff.sel.sb_valid = SEL_IN.sb_valid;
            nxt_eff.dual_lane = dual_ff;
            nxt_eff.sel.host_full = SEL_IN.host_full;
         end
         MGC_RATIO_5TO4: begin
            nxt_eff.sel.nb_bubble = SEL_IN.nb_bubble;
            nxt_eff.sel.host_full = SEL_IN.host_full;
            nxt_eff.dual_lane = 8'h00;
         end
         default: begin
            nxt_eff.dual_lane = 8'h00;  // 1:1 and reserved code
         end
      endcase
   end

   // Effective selector register
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         eff_ff <= '0;
      end else begin
         eff_ff <= nxt_eff;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign HRDATA = rdata_ff;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign EFF_OUT = eff_ff;
   assign TIMING_A = timing_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_dual_wr;
      addr_ok && HWRITE && {HADDR[13:2], 2'b00} == MGC_ADR_DUAL_LANE_CFG;
   endsequence
   sequence s_ratio_45;
      (mode_ff == 2'h3) [*2];
   endsequence

   chk_dual_wr_store: assert property (
      s_dual_wr ##1 1'b1 |=> dual_ff == $past(HWDATA[7:0]))
      else $error("dual-lane selector write lost");
   chk_dual_ignored_54: assert property (
      mode_ff == 2'h1 |=> EFF_OUT.dual_lane == 8'h00)
      else $error("dual-lane used in 5:4");
   chk_dual_used_45: assert property (
      s_ratio_45 |=> EFF_OUT.dual_lane == $past(dual_ff)
                     && EFF_OUT.sel.sb_valid == $past(SEL_IN.sb_valid))
      else $error("4:5 selectors not applied");
   chk_second_off: assert property (
      mode_ff != 2'h3 |=> EFF_OUT.sel.nb_gear_second == 32'h00000000)
      else $error("second gear used outside 4:5");
   chk_bubble_only_54: assert property (
      ##1 EFF_OUT.sel.nb_bubble ==
      ($past(mode_ff) == 2'h1 ? $past(SEL_IN.nb_bubble) : 8'h00))
      else $error("bubble selector gating wrong");
   chk_host_full_gate: assert property (
      ##1 EFF_OUT.sel.host_full == (($past(mode_ff) == 2'h1 ||
      $past(mode_ff) == 2'h3) ? $past(SEL_IN.host_full) : 8'h00))
      else $error("host-full selector gating wrong");
   chk_first_always: assert property (
      ##1 EFF_OUT.sel.nb_gear_first == $past(SEL_IN.nb_gear_first)
      && EFF_OUT.sel.sb_gear == $past(SEL_IN.sb_gear))
      else $error("always-used selectors not passed");
   chk_reset_zero: assert property (
      $rose(RST_N) |-> dual_ff == 8'h00 && EFF_OUT.cas_al == 3'h0)
      else $error("selector or latency not zero after reset");
   chk_dual_off_other: assert property (
      mode_ff != 2'h3 |=> EFF_OUT.dual_lane == 8'h00)
      else $error("dual-lane used outside 4:5");
   chk_valid_off_other: assert property (
      mode_ff != 2'h3 |=> EFF_OUT.sel.sb_valid == 8'h00)
      else $error("valid selector used outside 4:5");
   chk_cas_al_follow: assert property (
      ##1 EFF_OUT.cas_al == $past(timing_ff[MGC_TAL_MSB:MGC_TAL_LSB]))
      else $error("additive latency not passed on");
endmodule : mgc_gear_cfg

// File: tb/mgc_sel_src.sv
// ---------------------------------------------------------------
// Far-side model: raw gearing selectors
// ---------------------------------------------------------------
module mgc_sel_src import mgc_pkg::*; #(
   parameter mgc_sel_t PAT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pattern choice, inverse when high
   input wire logic alt,
   // Raw selectors toward the block
   output mgc_pkg::mgc_sel_t sel_out
);
   timeunit 1ns;
   timeprecision 1ps;
   mgc_sel_t nxt_sel; // Next selector set
   mgc_sel_t sel_ff;  // Registered selector set
   // Pick the plain or inverted pattern
   always_comb begin
      nxt_sel = alt ? ~PAT : PAT;
   end
   // Register, cleared in reset
   always_ff @(posedge clk) begin
      sel_ff <= rst_n ? nxt_sel : '0;
   end
   assign sel_out = sel_ff;
endmodule : mgc_sel_src

// File: tb/tb.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mgc_pkg::*;
   localparam mgc_sel_t PAT = 120'h11111111_22222222_33333333_44_55_66;
   localparam logic [31:0] A_TIM = 32'(MGC_ADR_DRAM_TIMING_A);
   localparam logic [31:0] A_DUL = 32'(MGC_ADR_DUAL_LANE_CFG);
   localparam logic [31:0] A_MOD = 32'(MGC_ADR_GEAR_MODE);
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, alt;
   logic [31:0] haddr, hwdata, hrdata, timing, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   mgc_sel_t sel;
   mgc_eff_t eff;
   int failures = 0, checks_done = 0;
   mgc_gear_cfg dut (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .SEL_IN(sel), .EFF_OUT(eff),
      .TIMING_A(timing));
   mgc_sel_src #(.PAT(PAT)) src (.clk(clk), .rst_n(rst_n), .alt(alt),
      .sel_out(sel));
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // One single-word transfer, waiting on ready in both phases
   task automatic ahb(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdv = hrdata;
   endtask : ahb
   // Expected selectors worked out from the ratio usage table
   function automatic mgc_eff_t exp_eff(input logic [1:0] m,
         input logic [7:0] d, input logic [2:0] tl, input mgc_sel_t s);
      mgc_eff_t e;
      e = '0;
      e.sel.nb_gear_first = s.nb_gear_first; // Used in every ratio
      e.sel.sb_gear = s.sb_gear;
      if (m == MGC_RATIO_4TO5) begin // Second gear, valid, dual, full
         e.sel.nb_gear_second = s.nb_gear_second;
         e.sel.sb_valid = s.sb_valid;
         e.sel.host_full = s.host_full;
         e.dual_lane = d;
      end
      if (m == MGC_RATIO_5TO4) begin // Bubble and full only
         e.sel.nb_bubble = s.nb_bubble;
         e.sel.host_full = s.host_full;
      end
      e.cas_al = tl;
      return e;
   endfunction : exp_eff
   // Reset values seen at registers and outputs
   task automatic t_reset;
      ahb(1'b0, A_TIM, 32'h0); `CHK(rdv, MGC_TIMING_RST)
      ahb(1'b0, A_DUL, 32'h0); `CHK(rdv, 32'h0)
      `CHK(eff, exp_eff(2'h0, 8'h00, 3'h0, PAT))
      `CHK(hresp, 1'b0)
      $display("t_reset done");
   endtask : t_reset
   // Timing register with read-only top bit and latency field
   task automatic t_timing;
      ahb(1'b1, A_TIM, 32'hFFFFFFFF);
      ahb(1'b0, A_TIM, 32'h0); `CHK(rdv, 32'h7FFFFFFF)
      repeat (2) @(posedge clk);
      `CHK(timing, 32'h7FFFFFFF)
      `CHK(eff.cas_al, 3'h7)
      ahb(1'b1, A_TIM, 32'h50000ABC);
      ahb(1'b0, A_TIM, 32'h0); `CHK(rdv, 32'h50000ABC)
      $display("t_timing done");
   endtask : t_timing
   // Every ratio, including reserved, with the suggested dual values
   task automatic t_modes;
      logic [1:0] md[5];
      logic [7:0] dl[5];
      md = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
      dl = '{8'h00, 8'h08, 8'h08, 8'h04, 8'h04};
      ahb(1'b1, A_TIM, 32'h20000000);
      for (int i = 0; i < 5; i++) begin
         // one choice applied to every selector
         alt <= i[0];
         ahb(1'b1, A_DUL, {24'h0, dl[i]});
         ahb(1'b1, A_MOD, {30'h0, md[i]});
         ahb(1'b0, A_DUL, 32'h0); `CHK(rdv, {24'h0, dl[i]})
         ahb(1'b0, A_MOD, 32'h0); `CHK(rdv, {30'h0, md[i]})
         repeat (3) @(posedge clk);
         `CHK(eff, exp_eff(md[i], dl[i], 3'h2, alt ? ~PAT : PAT))
      end
      $display("t_modes done");
   endtask : t_modes
   // Unmapped place reads zero and a write there changes nothing
   task automatic t_unmapped;
      ahb(1'b1, 32'h00000600, 32'hA5A5A5A5);
      ahb(1'b0, 32'h00000600, 32'h0); `CHK(rdv, 32'h0)
      ahb(1'b0, A_TIM, 32'h0); `CHK(rdv, 32'h20000000)
      $display("t_unmapped done");
   endtask : t_unmapped
   // Reset in mid-run clears selector, latency and ratio again
   task automatic t_rereset;
      ahb(1'b1, A_DUL, 32'h000000FF);
      ahb(1'b1, A_MOD, 32'h00000003);
      ahb(1'b1, A_TIM, 32'h70000000);
      repeat (3) @(posedge clk);
      `CHK(eff.dual_lane, 8'hFF)
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ahb(1'b0, A_DUL, 32'h0);
      `CHK(rdv, 32'h0)
      ahb(1'b0, A_TIM, 32'h0);
      `CHK(rdv, MGC_TIMING_RST)
      ahb(1'b0, A_MOD, 32'h0);
      `CHK(rdv, 32'h0)
      `CHK(timing, 32'h0)
      `CHK(eff, exp_eff(2'h0, 8'h00, 3'h0, PAT))
      $display("t_rereset done");
   endtask : t_rereset
   // Counts, verdict and end of run
   task automatic tally_and_finish;
      $display("Counts: checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; alt = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_timing;
      t_modes;
      t_unmapped;
      t_rereset;
      tally_and_finish;
   end
   // Watchdog well past the expected hundred-odd cycles
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      tally_and_finish;
   end
endmodule : tb
